// ### pqpt_far_model.sv
// Purpose: far-side load source and coprocessor privilege tracker
// Assumes: one register-file write per ld_go pulse
// Notes:   a released data bus shows the inverse of its last value
`timescale 1ns/1ps
`default_nettype none
module pqpt_far_model (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        arst_n,
    // command from the bench, and kernel_mode from the unit
    input  wire logic        ld_go,
    input  wire logic        ld_bad,
    input  wire logic        ld_unit,
    input  wire logic [63:0] ld_val,
    input  wire logic        kernel_mode,
    // register-file write side and privilege history
    output logic             rf_write,
    output logic             rf_from_unit,
    output logic      [63:0] rf_data,
    output logic      [7:0]  rf_parity,
    output logic      [2:0]  priv_q
);
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rf_write     <= 1'b0;
            rf_from_unit <= 1'b0;
            rf_data      <= 64'h0000_0000_0000_0000;
            rf_parity    <= 8'h00;
        end else if (ld_go) begin
            rf_write     <= 1'b1;
            rf_from_unit <= ld_unit;
            rf_data      <= ld_val;
            for (int i = 0; i < 8; i++) begin
                rf_parity[i] <= ~^ld_val[8*i+:8] ^ (ld_bad && i == 0);
            end
        end else begin
            rf_write  <= 1'b0;
            // released: never let a stale word pass as driven
            rf_data   <= ~rf_data;
            rf_parity <= ~rf_parity;
        end
    end
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            priv_q <= 3'h7;
        end else begin
            priv_q <= {priv_q[1:0], kernel_mode};
        end
    end
endmodule
`default_nettype wire

// ### pqpt_map.svh
// Purpose: offsets, field positions, reset values and counts for the pc queue
//          and parity trap unit
// Assumes: 32-bit program counters, 64-bit data with one parity bit per byte
// Notes:   definitions only
`ifndef PQPT_MAP_SVH
`define PQPT_MAP_SVH

// register word offsets on the avalon slave
`define PQPT_OFF_CTRL      4'h0
`define PQPT_OFF_STATUS    4'h1
`define PQPT_OFF_QUEUE     4'h2
`define PQPT_OFF_EXIT      4'h3
`define PQPT_OFF_QWRITE    4'h4
`define PQPT_OFF_FETCH     4'h5
`define PQPT_OFF_EXEC      4'h6
`define PQPT_OFF_MEM       4'h7
`define PQPT_OFF_WB        4'h8
`define PQPT_OFF_PSW       4'h9

// control register fields
`define PQPT_CTRL_PAR_EN   0
`define PQPT_CTRL_PERMIT   1
// status register fields
`define PQPT_ST_KERNEL     0
`define PQPT_ST_XLATE      1
`define PQPT_ST_PAR_ERR    2
`define PQPT_ST_INT        3

`define PQPT_RST_CTRL      2'h0
`define PQPT_RST_PSW       32'h0000_0000
`define PQPT_PSW_PC_LSB    4
`define PQPT_BYTES         8
`define PQPT_STAGES        4
`define PQPT_RET_DELAY     2'h1

`endif

// ### pqpt_pkg.sv
// Purpose: shared types of the pc queue and parity trap unit
// Assumes: nothing beyond the map header
// Notes:   types only
package pqpt_pkg;
    // return-from-kernel sequencing
    typedef enum logic [1:0] {
        PQPT_RET_IDLE  = 2'b00,
        PQPT_RET_SLOT  = 2'b01,
        PQPT_RET_LEAVE = 2'b10
    } pqpt_ret_type;
endpackage

// ### pqpt_unit.sv
// Purpose: pc history queue, byte parity check and generate, return from
//          kernel mode, reached over an avalon-mm slave
// Assumes: pipeline advance control and instruction buffer lie outside
// Notes:   stage 0 is fetch, 3 is writeback
// Contract
// - keep one pc entry per stage: fetch, execute, memory, writeback.
// - queue read returns writeback entry and shifts the queue by one.
// - loading a new fetch pc shifts the queue by one.
// - a bubble takes the pc of the next valid instruction behind it.
// - bubbles enter at wb/mem, mem/exec, exec/fetch on miss or interlock.
// - buffer miss injects two bubbles; refill fault seen at writeback.
// - each data byte carries one odd parity bit.
// - bad load parity with checking on raises interrupt next cycle; code raises it two cycles later.
// - stores drive correct parity together with the data.
// - alu, shift and extract results get parity in memory stage.
// - every register-file write has its parity checked.
// - operands read from the register file are never checked.
// - instruction parity checked on buffer read, not on buffer fill.
// - parity error on a buffer hit forces a miss, enable ignored.
// - bad parity on refill requested word raises interrupt next cycle; code raises it two cycles later.
// - bad parity on instruction after a miss forces another miss.
// - queue writes happen in memory stage, reads in execute stage.
// - reading the exit alias returns queue value and leaves kernel mode.
// - jump and kernel exit take effect after one delay slot.
// - buffer flush on every interrupt and every return from kernel.
// - kernel pin shows privilege of the instruction in fetch.
// - interrupt enters kernel, stops translation, fetches from psw.
// - queue holds still in kernel mode.
`include "pqpt_map.svh"
`timescale 1ns/1ps
`default_nettype none
module pqpt_unit #(
    parameter int PC_W = 32
) (
    // clock and reset
    input  wire logic              clk,
    input  wire logic              arst_n,
    // avalon-mm slave
    input  wire logic [3:0]        avs_address,
    input  wire logic              avs_read,
    input  wire logic              avs_write,
    input  wire logic [31:0]       avs_writedata,
    output logic      [31:0]       avs_readdata,
    output logic                   avs_waitrequest,
    // pipeline advance
    input  wire logic              fetch_load,
    input  wire logic [PC_W-1:0]   fetch_next_pc,
    input  wire logic              bubble_exec,
    input  wire logic              bubble_mem,
    input  wire logic              bubble_wb,
    input  wire logic              ext_interrupt,
    // register-file write path
    input  wire logic              rf_write,
    input  wire logic              rf_from_unit,
    input  wire logic [63:0]       rf_data,
    input  wire logic [7:0]        rf_parity,
    // functional-unit result bus in memory stage
    input  wire logic [63:0]       result_data,
    output logic      [7:0]        result_parity,
    // store data bus
    input  wire logic              store_drive,
    input  wire logic [63:0]       store_data,
    output logic      [63:0]       bus_data_out,
    output logic      [7:0]        bus_parity_out,
    output logic                   bus_data_oe,
    // instruction buffer read
    input  wire logic              ibuf_read,
    input  wire logic              ibuf_hit,
    input  wire logic              ibuf_refill_word,
    input  wire logic              ibuf_after_miss,
    input  wire logic [31:0]       ibuf_instr,
    input  wire logic [3:0]        ibuf_parity,
    output logic                   ibuf_force_miss,
    output logic                   ibuf_flush,
    // trap and mode
    output logic                   interrupt_out,
    output logic                   kernel_mode,
    output logic                   translate_en,
    output logic      [PC_W-1:0]   redirect_pc,
    output logic                   redirect_valid
);
    logic [PC_W-1:0] pcq_q [`PQPT_STAGES];
    logic [1:0]      ctrl_q;
    logic [31:0]     psw_q;
    logic            kernel_q;
    logic            xlate_q;
    logic            par_err_q;
    logic            int_q;
    logic            par_pend_q;
    logic [PC_W-1:0] ret_pc_q;
    logic [PC_W-1:0] wr_pc_q;
    logic            wr_pend_q;
    pqpt_pkg::pqpt_ret_type ret_q;
    logic [31:0]     rdata_q;
    logic            ack_q;

    logic            take_int;
    logic            acc;
    logic            fin;
    logic            q_read;
    logic            q_exit;
    logic            q_write;
    logic            advance;
    logic            rf_bad;
    logic            refill_bad;
    logic            hit_bad;

    // odd parity: data byte plus parity bit has an odd number of ones
    function automatic logic [7:0] pqpt_odd(input logic [63:0] d);
        logic [7:0] p;
        p = 8'h00;
        for (int i = 0; i < `PQPT_BYTES; i++) begin
            p[i] = ~(^d[i*8 +: 8]);
        end
        return p;
    endfunction

    function automatic logic [3:0] pqpt_odd32(input logic [31:0] d);
        logic [3:0] p;
        p = 4'h0;
        for (int i = 0; i < 4; i++) begin
            p[i] = ~(^d[i*8 +: 8]);
        end
        return p;
    endfunction

    // one-cycle wait state: every access answers on its second cycle
    assign acc             = (avs_read | avs_write) & ~ack_q;
    assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;
    assign avs_readdata    = rdata_q;
    // side effects only at the edge that completes the transfer
    assign fin             = (avs_read | avs_write) & ack_q;
    assign q_read  = fin & avs_read & (avs_address == `PQPT_OFF_QUEUE);
    assign q_exit  = fin & avs_read & (avs_address == `PQPT_OFF_EXIT);
    assign q_write = fin & avs_write & (avs_address == `PQPT_OFF_QWRITE);

    // interrupt gating; reset only sets kernel mode and clears translation
    assign take_int = ext_interrupt & ctrl_q[`PQPT_CTRL_PERMIT];
    assign advance  = (fetch_load | bubble_exec | bubble_mem | bubble_wb) &
                      ~kernel_q & ~take_int;

    assign rf_bad = rf_write & (pqpt_odd(rf_data) != rf_parity);
    assign hit_bad = ibuf_read &
                     (pqpt_odd32(ibuf_instr) != ibuf_parity);
    assign refill_bad = hit_bad & ibuf_refill_word;

    // hit with bad parity becomes a miss
    // instruction after a miss with bad parity also misses
    assign ibuf_force_miss = hit_bad & ~ibuf_refill_word &
                             (ibuf_hit | ibuf_after_miss);

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ack_q   <= 1'b0;
            rdata_q <= 32'h0000_0000;
        end else begin
            ack_q <= acc;
            if (acc && avs_read) begin
                unique case (avs_address)
                    `PQPT_OFF_CTRL:   rdata_q <= {30'h0000_0000, ctrl_q};
                    `PQPT_OFF_STATUS: rdata_q <= {28'h000_0000, int_q,
                                          par_err_q, xlate_q, kernel_q};
                    `PQPT_OFF_QUEUE,
                    `PQPT_OFF_EXIT:   rdata_q <= pcq_q[3];
                    `PQPT_OFF_FETCH:  rdata_q <= pcq_q[0];
                    `PQPT_OFF_EXEC:   rdata_q <= pcq_q[1];
                    `PQPT_OFF_MEM:    rdata_q <= pcq_q[2];
                    `PQPT_OFF_WB:     rdata_q <= pcq_q[3];
                    `PQPT_OFF_PSW:    rdata_q <= psw_q;
                    default:          rdata_q <= 32'h0000_0000;
                endcase
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ctrl_q <= `PQPT_RST_CTRL;
            psw_q  <= `PQPT_RST_PSW;
        end else if (fin && avs_write) begin
            if (avs_address == `PQPT_OFF_CTRL) begin
                ctrl_q <= avs_writedata[1:0];
            end
            if (avs_address == `PQPT_OFF_PSW) begin
                psw_q <= avs_writedata;
            end
        end
    end

    // software write lands one cycle later, in memory stage
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wr_pend_q <= 1'b0;
            wr_pc_q   <= '0;
        end else begin
            wr_pend_q <= q_write;
            if (q_write) begin
                wr_pc_q <= avs_writedata[PC_W-1:0];
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            for (int i = 0; i < `PQPT_STAGES; i++) begin
                pcq_q[i] <= '0;
            end
        end else if (advance) begin
            // bubble copies pc of entry behind it
            pcq_q[3] <= pcq_q[2];
            if (!bubble_wb) begin
                pcq_q[2] <= pcq_q[1];
            end
            if (!bubble_wb && !bubble_mem) begin
                pcq_q[1] <= pcq_q[0];
            end
            if (!bubble_wb && !bubble_mem && !bubble_exec) begin
                pcq_q[0] <= fetch_next_pc;
            end
        end else if (q_read || q_exit) begin
            pcq_q[3] <= pcq_q[2];
            pcq_q[2] <= pcq_q[1];
            pcq_q[1] <= pcq_q[0];
        end else if (wr_pend_q) begin
            pcq_q[0] <= wr_pc_q;
            pcq_q[1] <= pcq_q[0];
            pcq_q[2] <= pcq_q[1];
            pcq_q[3] <= pcq_q[2];
        end
    end

    // two miss bubbles in memory stage keep copying execute pc
    // so a refill fault at writeback still sees the pre-miss pc
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            par_pend_q <= 1'b0;
        end else begin
            // load or refill word parity error pends next cycle, interrupt one cycle after that
            par_pend_q <= ctrl_q[`PQPT_CTRL_PAR_EN] &
                          ((rf_bad & ~rf_from_unit) | refill_bad |
                           (rf_bad & rf_from_unit));
        end
    end

    // sticky error flag: a new error wins over software clear
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            par_err_q <= 1'b0;
        end else if (rf_bad || refill_bad) begin
            par_err_q <= 1'b1;
        end else if (fin && avs_write &&
                     avs_address == `PQPT_OFF_STATUS &&
                     avs_writedata[`PQPT_ST_PAR_ERR]) begin
            par_err_q <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            int_q <= 1'b0;
        end else begin
            int_q <= par_pend_q & ctrl_q[`PQPT_CTRL_PERMIT];
        end
    end
    assign interrupt_out = int_q;

    // return sequencing over one delay slot
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ret_q    <= pqpt_pkg::PQPT_RET_IDLE;
            ret_pc_q <= '0;
        end else begin
            unique case (ret_q)
                pqpt_pkg::PQPT_RET_IDLE: begin
                    if (q_exit && kernel_q) begin
                        ret_q    <= pqpt_pkg::PQPT_RET_SLOT;
                        ret_pc_q <= pcq_q[3];
                    end
                end
                pqpt_pkg::PQPT_RET_SLOT: begin
                    if (fetch_load) begin
                        ret_q <= pqpt_pkg::PQPT_RET_LEAVE;
                    end
                end
                pqpt_pkg::PQPT_RET_LEAVE: ret_q <= pqpt_pkg::PQPT_RET_IDLE;
                default: ret_q <= pqpt_pkg::PQPT_RET_IDLE;
            endcase
        end
    end

    // interrupt enters kernel and disables translation
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            kernel_q <= 1'b1;
            xlate_q  <= 1'b0;
        end else if (take_int) begin
            kernel_q <= 1'b1;
            xlate_q  <= 1'b0;
        end else if (ret_q == pqpt_pkg::PQPT_RET_LEAVE) begin
            kernel_q <= 1'b0;
            xlate_q  <= 1'b1;
        end
    end
    assign kernel_mode  = kernel_q;
    assign translate_en = xlate_q;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            redirect_pc    <= '0;
            redirect_valid <= 1'b0;
            ibuf_flush     <= 1'b0;
        end else begin
            redirect_valid <= take_int | (ret_q == pqpt_pkg::PQPT_RET_LEAVE);
            ibuf_flush     <= take_int | (ret_q == pqpt_pkg::PQPT_RET_LEAVE);
            if (take_int) begin
                redirect_pc <= {psw_q[31:`PQPT_PSW_PC_LSB], 4'h0};
            end else if (ret_q == pqpt_pkg::PQPT_RET_LEAVE) begin
                redirect_pc <= ret_pc_q;
            end
        end
    end

    // result parity generated in memory stage
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            result_parity <= 8'h00;
        end else begin
            result_parity <= pqpt_odd(result_data);
        end
    end

    // no check on the store operand path
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            bus_data_out   <= 64'h0000_0000_0000_0000;
            bus_parity_out <= 8'h00;
            bus_data_oe    <= 1'b0;
        end else begin
            bus_data_oe <= store_drive;
            if (store_drive) begin
                bus_data_out   <= store_data;
                bus_parity_out <= pqpt_odd(store_data);
            end
        end
    end

    // interrupt one cycle after the pending parity flag
    par_int_a: assert property (@(posedge clk) disable iff (!arst_n)
        (par_pend_q && ctrl_q[1]) |=> int_q)
        else $error("parity interrupt missing");
    st_par_a: assert property (@(posedge clk) disable iff (!arst_n)
        store_drive |=> (bus_parity_out == pqpt_odd(bus_data_out)))
        else $error("store parity wrong");
    hit_miss_a: assert property (@(posedge clk) disable iff (!arst_n)
        (hit_bad && ibuf_hit && !ibuf_refill_word) |-> ibuf_force_miss)
        else $error("bad hit not forced to miss");
    kq_hold_a: assert property (@(posedge clk) disable iff (!arst_n)
        (kernel_q && !q_read && !q_exit && !wr_pend_q)
        |=> (pcq_q[0] == $past(pcq_q[0])))
        else $error("queue moved in kernel");
    sequence ret_start_s;
        ret_q == pqpt_pkg::PQPT_RET_SLOT && fetch_load && !take_int;
    endsequence
    ret_slot_a: assert property (@(posedge clk) disable iff (!arst_n)
        (ret_start_s ##1 !take_int)
        |=> !kernel_q)
        else $error("kernel exit not after slot");
    int_flush_a: assert property (@(posedge clk) disable iff (!arst_n)
        take_int |=> (ibuf_flush && kernel_q && !translate_en))
        else $error("no flush on interrupt");
    rd_shift_a: assert property (@(posedge clk) disable iff (!arst_n)
        (q_read && !advance) |=> (pcq_q[3] == $past(pcq_q[2])))
        else $error("queue read did not shift");
    ld_shift_a: assert property (@(posedge clk) disable iff (!arst_n)
        (advance && fetch_load && !bubble_exec && !bubble_mem && !bubble_wb)
        |=> (pcq_q[0] == $past(fetch_next_pc)))
        else $error("fetch pc not loaded");
endmodule
`default_nettype wire

// ### pqpt_unit_bench.sv
// Purpose: self-checking bench of the pc queue and parity trap unit
// Assumes: queue writes shift even in kernel mode
// Notes:   expected read data queued by the driver, popped by a watcher
`include "pqpt_map.svh"
`timescale 1ns/1ps
`default_nettype none
module pqpt_unit_bench;
    logic        clk, arst_n, avs_read, avs_write, avs_waitrequest;
    logic [3:0]  avs_address, ibuf_parity;
    logic [31:0] avs_writedata, avs_readdata, fetch_next_pc, ibuf_instr;
    logic        fetch_load, bubble_exec, bubble_mem, bubble_wb;
    logic        ext_interrupt, rf_write, rf_from_unit, store_drive;
    logic [63:0] rf_data, result_data, store_data, bus_data_out, ld_val;
    logic [7:0]  rf_parity, result_parity, bus_parity_out;
    logic        bus_data_oe, ibuf_read, ibuf_hit, ibuf_refill_word;
    logic        ibuf_after_miss, ibuf_force_miss, ibuf_flush;
    logic        interrupt_out, kernel_mode, translate_en, redirect_valid;
    logic [31:0] redirect_pc, psw;
    logic        ld_go, ld_bad, ld_unit;
    logic [2:0]  priv_q;
    logic [63:0] v;
    logic [31:0] exp_q[$];
    int          fail_count, checks_done, cycles, seed;

    pqpt_unit #(.PC_W(32)) pqpt_unit_inst (.*);
    pqpt_far_model pqpt_far_model_inst (.*);

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    function automatic logic [7:0] oddpar(input logic [63:0] d);
        for (int i = 0; i < 8; i++) oddpar[i] = ~^d[8*i+:8];
    endfunction

    task automatic check(input logic [63:0] seen, input logic [63:0] want);
        checks_done++;
        if (seen !== want) begin
            fail_count++;
            $display("BAD t=%0t seen %h want %h", $time, seen, want);
        end
    endtask

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    // hold the request until waitrequest is seen low
    task automatic bus(input logic wr, input logic [3:0] a,
                       input logic [31:0] d);
        @(posedge clk);
        avs_address   <= a;
        avs_writedata <= d;
        avs_read      <= !wr;
        avs_write     <= wr;
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        bus(1'b0, a, 32'h0000_0000);
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask

    task automatic pulse_fetch(input logic [31:0] pc);
        @(posedge clk);
        fetch_load    <= 1'b1;
        fetch_next_pc <= pc;
        @(posedge clk);
        fetch_load <= 1'b0;
    endtask

    task automatic wait_redirect;
        int n;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (redirect_valid !== 1'b1 && n < 8);
        check(redirect_valid, 1'b1);
    endtask

    // called at the negedge of the cycle that carries the error
    task automatic trap_check(input logic yes);
        int n;
        n = 0;
        @(posedge clk);
        ibuf_read        <= 1'b0;
        ibuf_refill_word <= 1'b0;
        do begin
            @(negedge clk);
            n++;
        end while (interrupt_out !== 1'b1 && n < 6);
        if (yes) begin
            check(64'(n), 64'd2);
            // far side takes the raised interrupt back in
            @(posedge clk);
            ext_interrupt <= 1'b1;
            @(posedge clk);
            ext_interrupt <= 1'b0;
            wait_redirect();
            check(kernel_mode, 1'b1);
            check(translate_en, 1'b0);
            check(redirect_pc, {psw[31:4], 4'h0});
            check(ibuf_flush, 1'b1);
        end else begin
            check(64'(n), 64'd6);
        end
    endtask

    task automatic load(input logic bad, input logic unit, input logic yes);
        @(posedge clk);
        ld_go   <= 1'b1;
        ld_bad  <= bad;
        ld_unit <= unit;
        ld_val  <= {$random(seed), $random(seed)};
        @(posedge clk);
        ld_go <= 1'b0;
        do @(negedge clk); while (rf_write !== 1'b1);
        trap_check(yes);
    endtask

    task automatic exit_kernel(input logic [31:0] b);
        for (int i = 0; i < 4; i++) wr(`PQPT_OFF_QWRITE, b + 32'(4 * i));
        for (int i = 0; i < 4; i++) begin
            rd(`PQPT_OFF_FETCH + 4'(i), b + 32'(12 - 4 * i));
        end
        pulse_fetch(32'h0000_0f00);
        rd(`PQPT_OFF_FETCH, b + 32'd12);
        rd(`PQPT_OFF_QUEUE, b);
        rd(`PQPT_OFF_WB, b + 32'd4);
        rd(`PQPT_OFF_EXIT, b + 32'd4);
        @(negedge clk);
        check(kernel_mode, 1'b1);
        pulse_fetch(32'h0000_0f04);
        wait_redirect();
        check(kernel_mode, 1'b0);
        check(redirect_pc, b + 32'd4);
        check(ibuf_flush, 1'b1);
    endtask

    always @(posedge clk) begin
        if (avs_read === 1'b1 && avs_waitrequest === 1'b0) begin
            if (exp_q.size() > 0) check(avs_readdata, exp_q.pop_front());
        end
    end

    always @(posedge clk) begin
        cycles++;
        if (cycles == 6000) begin
            fail_count++;
            wrap_up();
        end
    end

    initial begin
        {avs_read, avs_write, fetch_load, bubble_exec, bubble_mem} = '0;
        {bubble_wb, ext_interrupt, store_drive, ibuf_read, ibuf_hit} = '0;
        {ibuf_refill_word, ibuf_after_miss, ld_go, ld_bad, ld_unit} = '0;
        {avs_address, ibuf_parity, ibuf_instr, ld_val} = '0;
        {avs_writedata, fetch_next_pc, result_data, store_data} = '0;
        {fail_count, checks_done, cycles} = '0;
        seed = 59252;
        arst_n = 1'b0;
        repeat (16) @(posedge clk);
        arst_n <= 1'b1;
        rd(`PQPT_OFF_CTRL, 32'(`PQPT_RST_CTRL));
        rd(`PQPT_OFF_STATUS, 32'h0000_0001);
        rd(`PQPT_OFF_PSW, `PQPT_RST_PSW);
        rd(4'hf, 32'h0000_0000);
        psw = $random(seed);
        wr(`PQPT_OFF_PSW, psw);
        exit_kernel(32'h0000_1000);
        pulse_fetch(32'h0000_4000);
        rd(`PQPT_OFF_FETCH, 32'h0000_4000);
        pulse_fetch(32'h0000_4004);
        rd(`PQPT_OFF_EXEC, 32'h0000_4000);
        @(posedge clk);
        bubble_exec <= 1'b1;
        @(posedge clk);
        bubble_exec <= 1'b0;
        rd(`PQPT_OFF_EXEC, 32'h0000_4004);
        wr(`PQPT_OFF_CTRL, 32'h0000_0002);
        load(1'b1, 1'b0, 1'b0);
        // hit bad, hit good, after-miss bad, bad but no read
        for (int c = 0; c < 4; c++) begin
            v = {$random(seed), $random(seed)};
            @(posedge clk);
            ibuf_instr      <= v[31:0];
            ibuf_read       <= (c != 3);
            ibuf_hit        <= (c != 2);
            ibuf_after_miss <= (c == 2);
            ibuf_parity     <= 4'(oddpar({32'h0, v[31:0]})) ^ 4'(c != 1);
            @(negedge clk);
            check(ibuf_force_miss, (c == 0 || c == 2));
        end
        ibuf_read <= 1'b0;
        for (int c = 0; c < 4; c++) begin
            v = {$random(seed), $random(seed)};
            @(posedge clk);
            store_drive <= 1'b1;
            store_data  <= v;
            result_data <= v;
            @(posedge clk);
            store_drive <= 1'b0;
            @(negedge clk);
            check(bus_data_out, v);
            check(bus_parity_out, oddpar(v));
            check(bus_data_oe, 1'b1);
            check(result_parity, oddpar(v));
        end
        wr(`PQPT_OFF_CTRL, 32'h0000_0003);
        load(1'b0, 1'b1, 1'b0);
        load(1'b1, 1'b0, 1'b1);
        exit_kernel(32'h0000_2000);
        load(1'b1, 1'b1, 1'b1);
        exit_kernel(32'h0000_3000);
        @(posedge clk);
        ibuf_instr       <= 32'h1234_5678;
        ibuf_parity      <= ~4'(oddpar(64'h1234_5678));
        ibuf_read        <= 1'b1;
        ibuf_hit         <= 1'b0;
        ibuf_after_miss  <= 1'b0;
        ibuf_refill_word <= 1'b1;
        @(negedge clk);
        trap_check(1'b1);
        rd(`PQPT_OFF_CTRL, 32'h0000_0003);
        wrap_up();
    end
endmodule
`default_nettype wire
